// ### verilog/rtccal_pkg.sv
// rtccal_pkg: constants shared by the calibration divider and its wrapper.
// assumes all counts are in oscillator ticks of a nominal 32768 hz source.
package rtccal_pkg;

  // ----------------------------------------------------------------
  // oscillator and divider chain
  // ----------------------------------------------------------------
  localparam int OSC_HZ = 32768;
  localparam int STAGE_DIV = 256;
  localparam int STAGE_PER_SEC = OSC_HZ / STAGE_DIV;
  localparam int BLANK_CNT = 128;
  localparam int INSERT_CNT = 256;
  localparam int SEC_LEN_NOM = OSC_HZ;
  localparam int SEC_LEN_POS = OSC_HZ - INSERT_CNT;
  localparam int SEC_LEN_NEG = OSC_HZ + BLANK_CNT;

  // ----------------------------------------------------------------
  // correction cycle and time counting
  // ----------------------------------------------------------------
  localparam int CYCLE_LAST = 63;
  localparam int ELIG_MIN = 62;
  localparam int SEC_LAST = 59;
  localparam int MIN_LAST = 59;

  // ----------------------------------------------------------------
  // register field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MAG_LSB = 0;
  localparam int CTRL_MAG_W = 5;
  localparam int CTRL_SIGN_BIT = 5;
  localparam int CTRL_FREEZE_BIT = 6;
  localparam int CTRL_LOAD_BIT = 7;
  localparam int DAY_FT_BIT = 6;
  localparam int WAVE_BIT = 5;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RD_RESET = 8'h00;
  localparam logic [4:0] MAG_RESET = 5'h00;

endpackage

// ### verilog/rtccal_div.sv
// rtccal_div: oscillator divider with count insertion or blanking at the
// divide-by-256 stage. assumes osc_tick pulses never come back to back.
`timescale 1ns/1ns
module rtccal_div (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // oscillator
  input wire logic osc_tick,
  input wire logic osc_run,
  // correction request for the current second
  input wire logic add_en,
  input wire logic blank_en,
  // one second pulse
  output logic sec_tick
);

  logic [7:0] pre_q;
  logic [6:0] stg_q;
  logic [6:0] blank_q;
  logic done_q;
  logic sec_q;
  logic step;
  logic blanking;
  logic adv;
  logic pulse256;
  logic ins;
  logic [7:0] sum;

  // ----------------------------------------------------------------
  // step decode
  // ----------------------------------------------------------------
  // blanking swallows ticks before the prescaler sees them
  assign step = osc_tick & osc_run;
  assign blanking = step & blank_en & ~done_q;
  assign adv = step & ~blanking;
  assign pulse256 = adv & (pre_q == 8'hff);
  assign ins = add_en & ~done_q;
  assign sum = {1'b0, stg_q} + (ins ? 8'h02 : 8'h01);
  assign sec_tick = sec_q;

  // prescaler, the raw divide-by-256 stage
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pre_q <= 8'h00;
    end else if (adv) begin
      pre_q <= pre_q + 8'h01;
    end
  end

  // upper stage; an inserted count skips one stage step
  always_ff @(posedge clock) begin
    if (!rstn) begin
      stg_q <= 7'h00;
    end else if (pulse256) begin
      stg_q <= sum[6:0];
    end
  end

  // blank counter, runs once at the start of a slowed second
  always_ff @(posedge clock) begin
    if (!rstn) begin
      blank_q <= 7'h00;
    end else if (sec_q) begin
      blank_q <= 7'h00;
    end else if (blanking) begin
      blank_q <= blank_q + 7'h01;
    end
  end

  // one correction per second at most
  always_ff @(posedge clock) begin
    if (!rstn) begin
      done_q <= 1'b0;
    end else if ((blanking && blank_q == 7'(rtccal_pkg::BLANK_CNT - 1)) || (pulse256 && ins)) begin
      done_q <= 1'b1;
    end else if (sec_q) begin
      done_q <= 1'b0;
    end
  end

  // second pulse lands one clock after the wrapping tick
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sec_q <= 1'b0;
    end else begin
      sec_q <= pulse256 & sum[7];
    end
  end

endmodule

// ### verilog/rtccal.sv
// rtccal: clock calibration and frequency test logic of a timekeeping ram.
// assumes osc_tick is a one-clock pulse per oscillator cycle and that the
// control and day bytes come straight from their storage cells.
//
// Overview of operation
// - count correction happens at divide-by-256 stage, oscillator untouched.
// - control bits four to zero give unsigned magnitude 0 to 31.
// - control bit five set means insert counts, clear means remove.
// - inserting makes the clock faster, removing makes it slower.
// - 64 minute cycle, only first 62 eligible, one second per minute.
// - corrected second gains 256 counts or loses 128 blanked counts.
// - magnitude n corrects exactly the first 2n minutes of the cycle.
// - frequency test bit set and oscillator running toggles seconds bit zero.
// - calibration never changes the test square wave.
// - prolonged seconds read without freeze shows the live wave on bit zero.
// - control byte holds load, freeze, sign and magnitude, high to low.
// - day byte bit six is frequency test, low three bits day of week.
// - freeze bit stops register updates while counters keep running.
`timescale 1ns/1ns
module rtccal (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // oscillator
  input wire logic osc_tick,
  input wire logic osc_run,
  // stored control and day bytes
  input wire logic [7:0] ctrl_reg,
  input wire logic [7:0] day_reg,
  // readable time registers
  output logic [7:0] seconds_rd,
  output logic [7:0] minutes_rd,
  output logic data_line_zero,
  // time pulses
  output logic sec_tick,
  output logic min_tick
);

  logic [5:0] sec_q;
  logic [5:0] min_q;
  logic [5:0] cyc_q;
  logic [4:0] mag_l_q;
  logic sign_l_q;
  logic [5:0] raw_q;
  logic upd_q;
  logic [7:0] sec_rd_q;
  logic [7:0] min_rd_q;
  logic dq0_q;
  logic step;
  logic hold;
  logic ft_act;
  logic elig;
  logic add_en;
  logic blank_en;
  logic min_roll;

  // binary 0..59 to packed bcd
  function automatic logic [7:0] to_bcd(input logic [5:0] v);
    logic [3:0] tens;
    logic [5:0] rem;
    tens = 4'(v / 6'd10);
    rem = v - 6'(tens) * 6'd10;
    to_bcd = {tens, rem[3:0]};
  endfunction

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  assign step = osc_tick & osc_run;
  assign hold = ctrl_reg[rtccal_pkg::CTRL_FREEZE_BIT] | ctrl_reg[rtccal_pkg::CTRL_LOAD_BIT];
  // test mode follows the bit alone; a stopped oscillator freezes the wave, not the mode
  assign ft_act = day_reg[rtccal_pkg::DAY_FT_BIT];
  assign min_roll = sec_tick & (sec_q == 6'(rtccal_pkg::SEC_LAST));
  assign min_tick = min_roll;

  // correction applies to second zero of the first 2n eligible minutes
  assign elig = (cyc_q < {mag_l_q, 1'b0}) && (cyc_q < 6'(rtccal_pkg::ELIG_MIN));
  assign add_en = elig && sec_q == 6'h00 && sign_l_q;
  assign blank_en = elig && sec_q == 6'h00 && !sign_l_q;

  // ----------------------------------------------------------------
  // divider chain
  // ----------------------------------------------------------------
  rtccal_div u_div (
    .clock(clock),
    .rstn(rstn),
    .osc_tick(osc_tick),
    .osc_run(osc_run),
    .add_en(add_en),
    .blank_en(blank_en),
    .sec_tick(sec_tick)
  );

  // running seconds and minutes counters, never frozen
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sec_q <= 6'h00;
      min_q <= 6'h00;
    end else if (sec_tick) begin
      sec_q <= min_roll ? 6'h00 : sec_q + 6'h01;
      if (min_roll) begin
        min_q <= (min_q == 6'(rtccal_pkg::MIN_LAST)) ? 6'h00 : min_q + 6'h01;
      end
    end
  end

  // free running cycle position wraps naturally at 64
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cyc_q <= 6'h00;
    end else if (min_roll) begin
      cyc_q <= cyc_q + 6'h01;
    end
  end

  // calibration sampled at minute edges so a minute is never half corrected
  always_ff @(posedge clock) begin
    if (!rstn) begin
      mag_l_q <= rtccal_pkg::MAG_RESET;
      sign_l_q <= 1'b0;
    end else if (min_roll) begin
      mag_l_q <= ctrl_reg[rtccal_pkg::CTRL_MAG_LSB +: rtccal_pkg::CTRL_MAG_W];
      sign_l_q <= ctrl_reg[rtccal_pkg::CTRL_SIGN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // frequency test
  // ----------------------------------------------------------------
  // raw tick counter sits ahead of the blanking, so calibration cannot skew it
  always_ff @(posedge clock) begin
    if (!rstn) begin
      raw_q <= 6'h00;
    end else if (step) begin
      raw_q <= raw_q + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // readable registers
  // ----------------------------------------------------------------
  // transfer one clock after the second pulse, skipped while held
  always_ff @(posedge clock) begin
    if (!rstn) begin
      upd_q <= 1'b0;
      sec_rd_q <= rtccal_pkg::RD_RESET;
      min_rd_q <= rtccal_pkg::RD_RESET;
    end else begin
      upd_q <= sec_tick;
      if (upd_q && !hold) begin
        sec_rd_q <= to_bcd(sec_q);
        min_rd_q <= to_bcd(min_q);
      end
    end
  end

  // bit zero is live wave under test; host must clear the bit to get time back
  always_ff @(posedge clock) begin
    if (!rstn) begin
      dq0_q <= 1'b0;
    end else begin
      dq0_q <= ft_act ? raw_q[rtccal_pkg::WAVE_BIT] : sec_rd_q[0];
    end
  end

  assign seconds_rd = {sec_rd_q[7:1], dq0_q};
  assign minutes_rd = min_rd_q;
  assign data_line_zero = dq0_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [15:0] len_q;
  logic len_ok_q;

  // tick count of each second; only seconds seen whole are judged
  always_ff @(posedge clock) begin
    if (!rstn) begin
      len_q <= 16'h0000;
      len_ok_q <= 1'b0;
    end else if (sec_tick) begin
      len_q <= {15'h0000, step};
      len_ok_q <= 1'b1;
    end else begin
      len_q <= len_q + {15'h0000, step};
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence min_edge_s;
    min_roll;
  endsequence

  sequence wave_rise_s;
    step && raw_q == 6'h1f ##1 ft_act [*2];
  endsequence

  sec_length_a: assert property (
    sec_tick && len_ok_q && osc_run |-> len_q == (add_en ? 16'(rtccal_pkg::SEC_LEN_POS) :
      blank_en ? 16'(rtccal_pkg::SEC_LEN_NEG) : 16'(rtccal_pkg::SEC_LEN_NOM)))
    else $error("second length does not match correction mode");

  cal_window_a: assert property (
    (add_en || blank_en) |-> cyc_q < {mag_l_q, 1'b0} && sec_q == 6'h00)
    else $error("correction outside first 2n minutes");

  late_minute_a: assert property (
    cyc_q >= 6'(rtccal_pkg::ELIG_MIN) |-> !add_en && !blank_en)
    else $error("correction in last two minutes of cycle");

  sign_direction_a: assert property (
    (add_en |-> sign_l_q) and (blank_en |-> !sign_l_q))
    else $error("correction direction disagrees with sign");

  cycle_wrap_a: assert property (
    min_edge_s ##0 cyc_q == 6'h3f |=> cyc_q == 6'h00 && mag_l_q == $past(ctrl_reg[4:0]))
    else $error("cycle or calibration latch wrong at minute edge");

  test_wave_a: assert property (
    wave_rise_s |-> data_line_zero && seconds_rd[0])
    else $error("test wave did not rise after 32 ticks");

  wave_raw_a: assert property (
    step && blank_en |=> raw_q == $past(raw_q) + 6'h01)
    else $error("test wave counter skewed by blanking");

  freeze_hold_a: assert property (
    hold && $past(hold) && !sec_tick |=> $stable(sec_rd_q) && $stable(min_rd_q))
    else $error("readable registers changed while held");

endmodule

// ### verif/rtccal_osc.sv
// rtccal_osc: behavioural crystal model giving one tick pulse per period.
// assumes it shares the system clock; the run gate is the bench's job.
`timescale 1ns/1ns
module rtccal_osc #(
  parameter int PERIOD = 3
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // oscillator tick
  output logic osc_tick
);
  int cnt;

  // quiet before the first falling edge
  initial begin
    cnt = 0;
    osc_tick = 1'b0;
  end

  // free-running crystal; pulses change on the falling edge, never back to back
  always @(negedge clock) begin
    if (!rstn) begin
      cnt <= 0;
      osc_tick <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      osc_tick <= (cnt == PERIOD - 1);
    end
  end
endmodule

// ### verif/rtccal_tb.sv
// rtccal_tb: self-checking bench for the calibration and frequency test block.
// assumes the crystal model at one tick every three clocks; one full second is run.
`timescale 1ns/1ns
module rtccal_tb;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic osc_run = 1'b0;
  logic [7:0] ctrl_reg = 8'h00;
  logic [7:0] day_reg = 8'h00;
  logic osc_tick;
  logic [7:0] seconds_rd;
  logic [7:0] minutes_rd;
  logic data_line_zero;
  logic sec_tick;
  logic min_tick;
  int mismatches = 0;
  int compares = 0;
  int ticks = 0;

  always #4 clock = ~clock;

  rtccal_osc #(.PERIOD(3)) u_osc (.clock(clock), .rstn(rstn), .osc_tick(osc_tick));

  rtccal u_dut (.clock(clock), .rstn(rstn), .osc_tick(osc_tick), .osc_run(osc_run),
    .ctrl_reg(ctrl_reg), .day_reg(day_reg), .seconds_rd(seconds_rd), .minutes_rd(minutes_rd),
    .data_line_zero(data_line_zero), .sec_tick(sec_tick), .min_tick(min_tick));

  // accepted ticks only; gated ticks must not count anywhere
  always @(posedge clock) begin
    if (!rstn) ticks <= 0;
    else if (osc_tick && osc_run) ticks <= ticks + 1;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ticks taken for the test line to reach lvl; bounded so a dead wave ends the run
  task automatic wait_wave(logic lvl, output int used);
    int start;
    start = ticks;
    for (int i = 0; i < 1000; i++) begin
      @(negedge clock);
      if (data_line_zero === lvl) begin
        used = ticks - start;
        return;
      end
    end
    mismatches++;
    $display("[ERR] wave level expected %b seen %b", lvl, data_line_zero);
    stop_test();
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    @(negedge clock);
    check("reset outputs", 32'h0, {seconds_rd, minutes_rd, data_line_zero, sec_tick, min_tick});
  endtask

  // square wave of 32 ticks a half period, unchanged by calibration written mid-minute, halted with the oscillator
  task automatic t_wave();
    int n;
    int bad;
    bad = 0;
    day_reg = 8'h40;
    osc_run = 1'b1;
    wait_wave(1'b1, n);
    check("wave rise ticks", 32'h20, n);
    wait_wave(1'b0, n);
    check("wave fall ticks", 32'h20, n);
    ctrl_reg = 8'h1f;
    wait_wave(1'b1, n);
    check("wave rise ticks slow cal", 32'h20, n);
    ctrl_reg = 8'h3f;
    wait_wave(1'b0, n);
    check("wave fall ticks fast cal", 32'h20, n);
    wait_wave(1'b1, n);
    osc_run = 1'b0;
    for (int i = 0; i < 300; i++) begin
      @(negedge clock);
      if (data_line_zero !== 1'b1) bad++;
    end
    check("wave held while stopped", 32'h0, bad);
    day_reg = 8'h00;
    repeat (3) @(negedge clock);
    check("line back to seconds bit", 32'h0, data_line_zero);
    check("seconds before first second", 32'h0, seconds_rd);
  endtask

  // the first second is nominal even with a full insert value loaded mid-minute
  task automatic t_second();
    ctrl_reg = 8'h3f;
    osc_run = 1'b1;
    // bound keeps the whole run under the cycle budget; a nominal second needs about 97800 here
    for (int i = 0; i < 99000; i++) begin
      @(negedge clock);
      if (sec_tick === 1'b1) break;
    end
    if (sec_tick !== 1'b1) begin
      mismatches++;
      $display("[ERR] sec_tick expected 1 seen %b", sec_tick);
      stop_test();
    end
    check("ticks in first second", 32'd32768, ticks);
    check("no minute tick", 32'h0, min_tick);
    repeat (3) @(negedge clock);
    check("seconds after one second", 32'h01, seconds_rd);
    check("bit zero after one second", 32'h1, data_line_zero);
    check("minutes unchanged", 32'h0, minutes_rd);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(negedge clock);
    rstn = 1'b1;
    t_reset();
    t_wave();
    t_second();
    stop_test();
  end
endmodule
